// [fmm_defs.svh]
// constants for the memory space map decoder
// assumes inclusion by the map modules only
`ifndef FMM_DEFS_SVH
`define FMM_DEFS_SVH
// size selection codes
`define FMM_SEL_4K        8'h61
`define FMM_SEL_8K        8'h42
`define FMM_SEL_16K       8'h04
`define FMM_SEL_32K       8'hc8
// rom top addresses
`define FMM_ROM_TOP_4K    16'h0fff
`define FMM_ROM_TOP_8K    16'h1fff
`define FMM_ROM_TOP_16K   16'h3fff
`define FMM_ROM_TOP_32K   16'h7fff
// high-speed ram base addresses, ram ends at fixed top
`define FMM_RAM_BASE_4K   16'hfd80
`define FMM_RAM_BASE_8K   16'hfd00
`define FMM_RAM_BASE_16K  16'hfc00
`define FMM_RAM_BASE_32K  16'hfb00
`define FMM_RAM_TOP       16'hfeff
`define FMM_SFR_BASE      16'hff00
// last valid block per capacity
`define FMM_BLK_LAST_4K   5'h03
`define FMM_BLK_LAST_8K   5'h07
`define FMM_BLK_LAST_16K  5'h0f
`define FMM_BLK_LAST_32K  5'h1f
// block field of the address
`define FMM_BLK_MSB       14
`define FMM_BLK_LSB       10
// option byte and security id areas, lower and swap copies
`define FMM_OPT_LO_BASE   16'h0080
`define FMM_OPT_LO_TOP    16'h0084
`define FMM_SID_LO_BASE   16'h0085
`define FMM_SID_LO_TOP    16'h008e
`define FMM_OPT_HI_BASE   16'h1080
`define FMM_OPT_HI_TOP    16'h1084
`define FMM_SID_HI_BASE   16'h1085
`define FMM_SID_HI_TOP    16'h108e
// boot cluster 0 covers the first 4 kb
`define FMM_BC0_TOP       16'h0fff
`endif

// [fmm_pkg.sv]
// types shared by the memory space map decoder
// assumes fmm_defs.svh is on the include path
package fmm_pkg;
    // configured rom capacity
    typedef enum logic [2:0]
    {
        FMM_CAP_NONE,
        FMM_CAP_4K,
        FMM_CAP_8K,
        FMM_CAP_16K,
        FMM_CAP_32K
    } fmm_cap_t;
    // region reached by an address
    typedef enum logic [2:0]
    {
        FMM_REG_ROM,
        FMM_REG_RAM,
        FMM_REG_SFR,
        FMM_REG_HOLE
    } fmm_region_t;
endpackage : fmm_pkg

// [fmm_cfg_reg.sv]
// size selection holder: latches the code software writes
// assumes write strobe and data come from the cpu clock domain
`timescale 1ns/1ns
`include "fmm_defs.svh"
module fmm_cfg_reg
    import fmm_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       resetn_in,
    input  wire logic       ce_in,
    input  wire logic       wr_in,
    input  wire logic [7:0] data_in,
    output fmm_cap_t        cap_out,
    output logic [7:0]      code_out
);
    // decode a size code into a capacity
    function automatic fmm_cap_t fmm_code_to_cap(input logic [7:0] c);
        if (c == `FMM_SEL_4K)
            fmm_code_to_cap = FMM_CAP_4K;
        else if (c == `FMM_SEL_8K)
            fmm_code_to_cap = FMM_CAP_8K;
        else if (c == `FMM_SEL_16K)
            fmm_code_to_cap = FMM_CAP_16K;
        else if (c == `FMM_SEL_32K)
            fmm_code_to_cap = FMM_CAP_32K;
        else
            fmm_code_to_cap = FMM_CAP_NONE;
    endfunction : fmm_code_to_cap

    // undefined after reset: held as no capacity until written
    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
        begin
            cap_out  <= FMM_CAP_NONE;
            code_out <= 8'h00;
        end
        else if (ce_in && wr_in)
        begin
            cap_out  <= fmm_code_to_cap(data_in);
            code_out <= data_in;
        end
    end
endmodule : fmm_cfg_reg

// [fmm_space_map.sv]
// memory space map: decodes cpu addresses into rom/ram/sfr,
// flash block numbers, option byte and security id windows
// assumes address, strobes and straps come from the cpu clock domain
// one clock, synchronous active-low reset, low ce freezes all state
`timescale 1ns/1ns
`include "fmm_defs.svh"
// Behaviour
// R1 - one 64 kb space, 16-bit addresses
// R2 - layout unusable until size code written
// R3 - size code selects rom and ram size
// R4 - flash in 1 kb blocks from zero
// R5 - valid blocks follow rom capacity
// R6 - option bytes and id at low area
// R7 - boot swap adds copies at 1080h
// R8 - protected boot cluster 0 rejects writes
// R9 - block index from address bits 14:10
module fmm_space_map
    import fmm_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    input  wire logic        ce_in,
    input  wire logic [15:0] addr_in,
    input  wire logic        fetch_in,
    input  wire logic        rd_in,
    input  wire logic        wr_in,
    input  wire logic        erase_in,
    input  wire logic        size_wr_in,
    input  wire logic [7:0]  size_data_in,
    input  wire logic        boot_swap_in,
    input  wire logic        bc0_protect_in,
    output logic             cfg_valid_out,
    output logic [7:0]       size_code_out,
    output logic             rom_sel_out,
    output logic             ram_sel_out,
    output logic             sfr_sel_out,
    output logic             hole_out,
    output logic [4:0]       block_out,
    output logic             block_valid_out,
    output logic             opt_sel_out,
    output logic [2:0]       opt_index_out,
    output logic             sid_sel_out,
    output logic [3:0]       sid_index_out,
    output logic             write_reject_out
);
    // ****************************************************
    // size configuration
    // ****************************************************
    fmm_cap_t    cap;
    logic [7:0]  code;

    // holder keeps the written code; code-out mirrors it
    fmm_cfg_reg u_cfg
    (
        .clk_sys_in (clk_sys_in),
        .resetn_in  (resetn_in),
        .ce_in      (ce_in),
        .wr_in      (size_wr_in),
        .data_in    (size_data_in),
        .cap_out    (cap),
        .code_out   (code)
    );

    // ****************************************************
    // decode helpers
    // ****************************************************
    // inclusive window test shared by the ram, option and id areas
    function automatic logic fmm_in_range(input logic [15:0] a,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        fmm_in_range = (a >= lo) && (a <= hi);
    endfunction : fmm_in_range

    // no capacity falls to the largest map; cfg_ok masks it anyway
    function automatic logic [15:0] fmm_rom_top(input fmm_cap_t c);
        case (c)
            FMM_CAP_4K:  fmm_rom_top = `FMM_ROM_TOP_4K;
            FMM_CAP_8K:  fmm_rom_top = `FMM_ROM_TOP_8K;
            FMM_CAP_16K: fmm_rom_top = `FMM_ROM_TOP_16K;
            default:     fmm_rom_top = `FMM_ROM_TOP_32K;
        endcase
    endfunction : fmm_rom_top

    function automatic logic [15:0] fmm_ram_base(input fmm_cap_t c);
        case (c)
            FMM_CAP_4K:  fmm_ram_base = `FMM_RAM_BASE_4K;
            FMM_CAP_8K:  fmm_ram_base = `FMM_RAM_BASE_8K;
            FMM_CAP_16K: fmm_ram_base = `FMM_RAM_BASE_16K;
            default:     fmm_ram_base = `FMM_RAM_BASE_32K;
        endcase
    endfunction : fmm_ram_base

    // last block number per capacity, in step with the rom top
    function automatic logic [4:0] fmm_blk_last(input fmm_cap_t c);
        case (c)
            FMM_CAP_4K:  fmm_blk_last = `FMM_BLK_LAST_4K;
            FMM_CAP_8K:  fmm_blk_last = `FMM_BLK_LAST_8K;
            FMM_CAP_16K: fmm_blk_last = `FMM_BLK_LAST_16K;
            default:     fmm_blk_last = `FMM_BLK_LAST_32K;
        endcase
    endfunction : fmm_blk_last

    // ****************************************************
    // combinational decode
    // ****************************************************
    // layout, low to high: rom from 0000h to its top, a hole,
    // high-speed ram from its base to feffh, sfrs at ff00h-ffffh.
    // an unwritten size code leaves rom and ram as hole, so a cpu
    // that skips the size write sees holes rather than stale rom
    // any access kind reaches the same 64 kb space
    wire       access  = fetch_in | rd_in | wr_in | erase_in;  // R1
    wire       cfg_ok  = (cap != FMM_CAP_NONE);                // R2
    wire [15:0] rom_top  = fmm_rom_top(cap);                   // R3
    wire [15:0] ram_base = fmm_ram_base(cap);                  // R3
    // with no size written only the sfrs map, so misuse shows
    wire in_rom = cfg_ok && (addr_in <= rom_top);              // R2
    wire in_ram = cfg_ok
                  && fmm_in_range(addr_in, ram_base, `FMM_RAM_TOP);
    wire in_sfr = (addr_in >= `FMM_SFR_BASE);
    wire in_hole = !in_rom && !in_ram && !in_sfr;

    // block index straight from the address field
    wire [4:0] blk = addr_in[`FMM_BLK_MSB:`FMM_BLK_LSB];       // R9 R4
    wire       blk_ok = in_rom && (blk <= fmm_blk_last(cap));  // R5

    // option bytes and security id, swap copies when swapping
    wire opt_lo = fmm_in_range(addr_in, `FMM_OPT_LO_BASE,
                               `FMM_OPT_LO_TOP);               // R6
    wire sid_lo = fmm_in_range(addr_in, `FMM_SID_LO_BASE,
                               `FMM_SID_LO_TOP);               // R6
    wire opt_hi = boot_swap_in && in_rom
                  && fmm_in_range(addr_in, `FMM_OPT_HI_BASE,
                                  `FMM_OPT_HI_TOP);            // R7
    wire sid_hi = boot_swap_in && in_rom
                  && fmm_in_range(addr_in, `FMM_SID_HI_BASE,
                                  `FMM_SID_HI_TOP);            // R7
    wire opt_hit = cfg_ok && (opt_lo || opt_hi);
    wire sid_hit = cfg_ok && (sid_lo || sid_hi);
    wire [15:0] opt_off = addr_in - (opt_hi ? `FMM_OPT_HI_BASE
                                            : `FMM_OPT_LO_BASE);
    wire [15:0] sid_off = addr_in - (sid_hi ? `FMM_SID_HI_BASE
                                            : `FMM_SID_LO_BASE);

    // protected cluster refuses writes and erases
    // status only: the write path itself is gated by the flash side
    wire in_bc0 = in_rom && (addr_in <= `FMM_BC0_TOP);
    wire reject = (wr_in || erase_in) && in_bc0
                  && bc0_protect_in;                           // R8

    // ****************************************************
    // next values of the flopped outputs
    // ****************************************************
    // selects fire only on a real access so idle cycles stay quiet;
    // the block number is passed on regardless, for trace use
    wire       next_rom_sel     = access && in_rom;  // R3
    wire       next_ram_sel     = access && in_ram;  // R3
    wire       next_sfr_sel     = access && in_sfr;  // R1
    wire       next_hole        = access && in_hole; // R1
    wire       next_block_valid = access && blk_ok;  // R5
    wire       next_opt_sel     = access && opt_hit; // R6
    wire       next_sid_sel     = access && sid_hit; // R6
    // offsets cut to the window sizes: 5 option bytes, 10 id bytes
    wire [2:0] next_opt_index   = opt_off[2:0];
    wire [3:0] next_sid_index   = sid_off[3:0];

    // ****************************************************
    // registered outputs
    // ****************************************************
    // one cycle of latency keeps every output on a flop
    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
        begin
            rom_sel_out      <= 1'b0;
            ram_sel_out      <= 1'b0;
            sfr_sel_out      <= 1'b0;
            hole_out         <= 1'b0;
            block_valid_out  <= 1'b0;
            write_reject_out <= 1'b0;
        end
        else if (ce_in)
        begin
            rom_sel_out      <= next_rom_sel;
            ram_sel_out      <= next_ram_sel;
            sfr_sel_out      <= next_sfr_sel;
            hole_out         <= next_hole;
            block_valid_out  <= next_block_valid;              // R5
            write_reject_out <= reject;                        // R8
        end
    end

    // block number and window offsets; low ce holds them for the cpu
    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
        begin
            block_out     <= 5'h00;
            opt_sel_out   <= 1'b0;
            opt_index_out <= 3'h0;
            sid_sel_out   <= 1'b0;
            sid_index_out <= 4'h0;
        end
        else if (ce_in)
        begin
            block_out     <= blk;                              // R9
            opt_sel_out   <= next_opt_sel;
            opt_index_out <= next_opt_index;
            sid_sel_out   <= next_sid_sel;
            sid_index_out <= next_sid_index;
        end
    end

    // status copies of the configuration, also flopped
    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
        begin
            cfg_valid_out <= 1'b0;
            size_code_out <= 8'h00;
        end
        else if (ce_in)
        begin
            cfg_valid_out <= cfg_ok;                           // R2
            size_code_out <= code;
        end
    end
endmodule : fmm_space_map

// [fmm_space_map_checker.sv]
// checker: timing relations of the space map outputs
// assumes bind onto fmm_space_map, one clock, sync reset
`timescale 1ns/1ns
module fmm_space_map_checker
(
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    input  wire logic        ce_in,
    input  wire logic [15:0] addr_in,
    input  wire logic        rd_in,
    input  wire logic        wr_in,
    input  wire logic        size_wr_in,
    input  wire logic        bc0_protect_in,
    input  wire logic        cfg_valid_out,
    input  wire logic [7:0]  size_code_out,
    input  wire logic        rom_sel_out,
    input  wire logic        sfr_sel_out,
    input  wire logic [4:0]  block_out,
    input  wire logic        block_valid_out,
    input  wire logic        opt_sel_out,
    input  wire logic [2:0]  opt_index_out,
    input  wire logic        sid_sel_out,
    input  wire logic [3:0]  sid_index_out,
    input  wire logic        write_reject_out
);
    // ********************************
    // properties
    // ********************************
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);
    // no size write in the last two edges, so size_code_out is current
    sequence s_set;
        ce_in && cfg_valid_out && !$past(size_wr_in)
            && !$past(size_wr_in, 2);
    endsequence
    AST_BLK: assert property (ce_in |=> block_out == $past(addr_in[14:10]))
        else $error("block number not from address");
    AST_SFR: assert property (ce_in && rd_in && addr_in[15:8] == 8'hff
        |=> sfr_sel_out && !rom_sel_out) else $error("sfr decode wrong");
    AST_OPT: assert property (s_set ##0 (rd_in
        && addr_in inside {[16'h0080:16'h0084]}) |=> opt_sel_out
        && opt_index_out == $past(addr_in[2:0])) else $error("opt miss");
    AST_SID: assert property (s_set ##0 (rd_in
        && addr_in inside {[16'h0085:16'h008e]}) |=> sid_sel_out
        && sid_index_out == $past(addr_in[3:0]) - 4'h5) else $error("sid");
    AST_REJ: assert property (s_set ##0 (wr_in && bc0_protect_in
        && addr_in[15:12] == 4'h0) |=> write_reject_out)
        else $error("protected write not rejected");
    AST_NREJ: assert property (ce_in && !bc0_protect_in
        |=> !write_reject_out) else $error("reject while unprotected");
    AST_NCFG: assert property (ce_in && !cfg_valid_out && !$past(size_wr_in)
        |=> !rom_sel_out && !block_valid_out) else $error("rom before code");
    AST_K32: assert property (s_set ##0 (rd_in && size_code_out == 8'hc8
        && !addr_in[15]) |=> rom_sel_out && block_valid_out)
        else $error("32k rom block invalid");
    AST_FRZ: assert property (!ce_in |=> $stable(block_out)
        && $stable(rom_sel_out) && $stable(cfg_valid_out)
        && $stable(size_code_out)) else $error("state moved while frozen");
endmodule : fmm_space_map_checker
bind fmm_space_map fmm_space_map_checker fmm_space_map_checker_inst (.*);

// [fmm_cpu_model.sv]
// cpu core model: drives addresses, access kinds and size writes
// assumes callers enter its tasks from the bench's main sequence
`timescale 1ns/1ns
module fmm_cpu_model
(
    input  wire logic        clk_sys_in,
    output logic [15:0]      addr_out,
    output logic [3:0]       kind_out,
    output logic             size_wr_out,
    output logic [7:0]       size_data_out
);
    // ********************************
    // bus tasks
    // ********************************
    // idle values at time zero
    initial
    begin
        addr_out = 16'h0000;
        kind_out = 4'h0;
        size_wr_out = 1'b0;
        size_data_out = 8'h00;
    end
    // kind is fetch,rd,wr,erase; held until the next access
    task access(input logic [15:0] a, input logic [3:0] k);
        @(posedge clk_sys_in);
        addr_out <= a;
        kind_out <= k;
        @(posedge clk_sys_in);
        #1;
    endtask : access
    // one-cycle size write; data inverted after so no stale value lingers
    task set_size(input logic [7:0] c);
        @(posedge clk_sys_in);
        size_wr_out <= 1'b1;
        size_data_out <= c;
        @(posedge clk_sys_in);
        size_wr_out <= 1'b0;
        size_data_out <= ~c;
    endtask : set_size
endmodule : fmm_cpu_model

// [fmm_space_map_bench.sv]
// bench for the space map: cpu model drives, tasks judge outputs
// assumes fmm_cpu_model and the bound checker are compiled first
`timescale 1ns/1ns
module fmm_space_map_bench;
    import fmm_pkg::*;
    logic        clk_sys_in, resetn_in, ce_in, boot_swap_in, bc0_protect_in;
    logic [15:0] addr;
    logic [3:0]  kind, sidx;
    logic [7:0]  sdat, scode;
    logic        swr, cfgv, rom, ram, sfr, bval, opt, sid, rej, hole;
    logic [4:0]  blk;
    logic [2:0]  oidx;
    int          mismatches, n_compared, cyc;
    logic [7:0]  codes [4] = '{8'h61, 8'h42, 8'h04, 8'hc8};
    logic [15:0] rtop [4] = '{16'h0fff, 16'h1fff, 16'h3fff, 16'h7fff};
    logic [15:0] rbase [4] = '{16'hfd80, 16'hfd00, 16'hfc00, 16'hfb00};
    fmm_cpu_model cpu (.clk_sys_in(clk_sys_in), .addr_out(addr),
        .kind_out(kind), .size_wr_out(swr), .size_data_out(sdat));
    fmm_space_map fmm_space_map_inst (.clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in), .ce_in(ce_in), .addr_in(addr),
        .fetch_in(kind[3]), .rd_in(kind[2]), .wr_in(kind[1]),
        .erase_in(kind[0]), .size_wr_in(swr), .size_data_in(sdat),
        .boot_swap_in(boot_swap_in), .bc0_protect_in(bc0_protect_in),
        .cfg_valid_out(cfgv), .size_code_out(scode), .rom_sel_out(rom),
        .ram_sel_out(ram), .sfr_sel_out(sfr), .hole_out(hole),
        .block_out(blk), .block_valid_out(bval), .opt_sel_out(opt),
        .opt_index_out(oidx), .sid_sel_out(sid), .sid_index_out(sidx),
        .write_reject_out(rej));
    // ********************************
    // helpers
    // ********************************
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    // protect level changes on an edge, then one write or erase
    task rj(input logic p, input logic [15:0] a, input logic [3:0] k,
            input logic e);
        @(posedge clk_sys_in);
        bc0_protect_in <= p;
        cpu.access(a, k);
        chk("reject", rej, e);
    endtask : rj
    // ********************************
    // scenarios
    // ********************************
    task t_reset;
        cpu.access(16'h0080, 4'h4);
        chk("rom", rom, 1'b0);
        chk("opt", opt, 1'b0);
        chk("hole", hole, 1'b1);
        cpu.access(16'hff10, 4'h4);
        chk("sfr", sfr, 1'b1);
    endtask : t_reset
    // every size code: rom top, first beyond, ram base and below it
    task t_codes;
        for (int i = 0; i < 4; i++)
        begin
            cpu.set_size(codes[i]);
            cpu.access(rtop[i], 4'h8);
            chk("rom", rom, 1'b1);
            chk("blk", blk, rtop[i][14:10]);
            chk("bval", bval, 1'b1);
            chk("code", scode, codes[i]);
            cpu.access(rtop[i] + 16'h0001, 4'h4);
            chk("rom", rom, 1'b0);
            chk("bval", bval, 1'b0);
            cpu.access(rbase[i], 4'h4);
            chk("ram", ram, 1'b1);
            chk("hole", hole, 1'b0);
            cpu.access(rbase[i] - 16'h0001, 4'h4);
            chk("ram", ram, 1'b0);
            chk("hole", hole, 1'b1);
        end
    endtask : t_codes
    task t_blocks;
        for (int b = 0; b < 32; b++)
        begin
            cpu.access({1'b0, b[4:0], 10'h3ff}, 4'h4);
            chk("blk", blk, b[4:0]);
        end
    endtask : t_blocks
    task t_opt;
        cpu.access(16'h0084, 4'h4);
        chk("oidx", oidx, 3'h4);
        cpu.access(16'h008e, 4'h4);
        chk("sidx", sidx, 4'h9);
        cpu.access(16'h1080, 4'h4);
        chk("opt", opt, 1'b0);
        @(posedge clk_sys_in);
        boot_swap_in <= 1'b1;
        cpu.access(16'h1084, 4'h4);
        chk("opt", {opt, oidx}, 4'hc);
        cpu.access(16'h1085, 4'h4);
        chk("sid", {sid, sidx}, 5'h10);
        cpu.access(16'h008f, 4'h4);
        chk("sid", sid, 1'b0);
    endtask : t_opt
    task t_bad_code;
        cpu.set_size(8'h55);
        cpu.access(16'h0000, 4'h8);
        chk("rom", rom, 1'b0);
        cpu.access(16'h0001, 4'h8);
        chk("cfgv", cfgv, 1'b0);
    endtask : t_bad_code
    // protect level against writes inside and beyond cluster 0 and an erase inside it
    task t_reject;
        rj(1'b1, 16'h0fff, 4'h2, 1'b1);
        rj(1'b1, 16'h1000, 4'h2, 1'b0);
        rj(1'b1, 16'h0000, 4'h1, 1'b1);
        rj(1'b0, 16'h0fff, 4'h2, 1'b0);
    endtask : t_reject
    // low enable freezes decode and a size write made meanwhile
    task t_freeze;
        cpu.set_size(8'hc8);
        cpu.access(16'h0400, 4'h4);
        chk("blk", blk, 5'h01);
        @(posedge clk_sys_in);
        ce_in <= 1'b0;
        cpu.access(16'hff00, 4'h4);
        chk("rom", rom, 1'b1);
        chk("sfr", sfr, 1'b0);
        chk("blk", blk, 5'h01);
        cpu.set_size(8'h55);
        @(posedge clk_sys_in);
        ce_in <= 1'b1;
        cpu.access(16'h0800, 4'h4);
        chk("blk", blk, 5'h02);
        chk("cfgv", cfgv, 1'b1);
        chk("code", scode, 8'hc8);
    endtask : t_freeze
    // a reset in mid-run drops the written size again
    task t_rst_mid;
        cpu.set_size(8'h61);
        cpu.access(16'h0000, 4'h8);
        chk("rom", rom, 1'b1);
        @(posedge clk_sys_in);
        resetn_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        cpu.access(16'h0000, 4'h8);
        chk("rom", rom, 1'b0);
        chk("cfgv", cfgv, 1'b0);
        chk("code", scode, 8'h00);
    endtask : t_rst_mid
    // ********************************
    // clock, timeout, main sequence
    // ********************************
    initial
    begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            mismatches++;
            summarize();
        end
    end
    initial
    begin
        resetn_in = 1'b0;
        ce_in = 1'b1;
        boot_swap_in = 1'b0;
        bc0_protect_in = 1'b0;
        mismatches = 0;
        n_compared = 0;
        cyc = 0;
        repeat (10) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        t_reset();
        t_codes();
        t_blocks();
        t_opt();
        t_reject();
        t_freeze();
        t_bad_code();
        t_rst_mid();
        summarize();
    end
endmodule : fmm_space_map_bench
